// [ptcb_defines.vh]
// constants for the timer and counter bank
`ifndef PTCB_DEFINES_VH
`define PTCB_DEFINES_VH
`define PTCB_CLK_HZ 100000000
`define PTCB_TENTH_MS 100
`define PTCB_HUNDREDTH_MS 10
`define PTCB_TENTH_CYC ((`PTCB_CLK_HZ / 1000) * `PTCB_TENTH_MS)
`define PTCB_HUNDREDTH_CYC ((`PTCB_CLK_HZ / 1000) * `PTCB_HUNDREDTH_MS)
`define PTCB_SHORT_MAX 14'h270f
`define PTCB_LONG_MAX 27'h5f5e0ff
`define PTCB_CNT_BASE 11'h3e8
`define PTCB_TMR_NUM_W 6
`define PTCB_VAL_ADDR_W 11
`endif

// [ptcb_timer_counter_bank.v]
// bank of tenth/hundredth timers, accumulating timers and three counter types
`timescale 1ns/1ps
`include "ptcb_defines.vh"
module ptcb_timer_counter_bank #(
  parameter TENTH_CYC = `PTCB_TENTH_CYC,
  parameter HUNDREDTH_CYC = `PTCB_HUNDREDTH_CYC
) (
  input wire clk_i,
  input wire srst_i,
  // timers: 0 tenth, 1 hundredth, 2/3 acc tenth, 4/5 acc hundredth
  input wire tenth_second_timer_in_i,
  input wire [13:0] tenth_second_timer_preset_i,
  input wire hundredth_second_timer_in_i,
  input wire [13:0] hundredth_second_timer_preset_i,
  input wire accumulating_tenth_timer_en_i,
  input wire accumulating_tenth_timer_rst_i,
  input wire [26:0] accumulating_tenth_timer_preset_i,
  input wire accumulating_hundredth_timer_en_i,
  input wire accumulating_hundredth_timer_rst_i,
  input wire [26:0] accumulating_hundredth_timer_preset_i,
  // counters: 0 up, 1/2 up-down, 3 stage
  input wire up_counter_count_i,
  input wire up_counter_rst_i,
  input wire [13:0] up_counter_preset_i,
  input wire up_down_counter_up_i,
  input wire up_down_counter_down_i,
  input wire up_down_counter_rst_i,
  input wire [26:0] up_down_counter_preset_i,
  input wire stage_counter_count_i,
  input wire stage_counter_rst_cmd_i,
  input wire [13:0] stage_counter_preset_i,
  // value memory read port
  input wire [10:0] value_addr_i,
  output reg [15:0] value_data_o,
  output reg [5:0] timer_status_o,
  output reg [3:0] counter_bit_space_o
);

  reg [31:0] tenth_div;
  reg [31:0] hund_div;
  reg [31:0] next_tenth_div;
  reg [31:0] next_hund_div;
  reg tenth_tick;
  reg hund_tick;
  reg next_tenth_tick;
  reg next_hund_tick;
  reg [13:0] tmr_t;
  reg [13:0] tmr_h;
  reg [26:0] acc_t;
  reg [26:0] acc_h;
  reg [13:0] cnt_up;
  reg [26:0] cnt_ud;
  reg [13:0] cnt_sg;
  reg [13:0] next_tmr_t;
  reg [13:0] next_tmr_h;
  reg [26:0] next_acc_t;
  reg [26:0] next_acc_h;
  reg [13:0] next_cnt_up;
  reg [26:0] next_cnt_ud;
  reg [13:0] next_cnt_sg;
  reg up_q;
  reg ud_up_q;
  reg ud_dn_q;
  reg sg_q;
  reg [15:0] next_value;
  reg [5:0] next_timer_status;
  reg [3:0] next_counter_bits;
  wire up_edge;
  wire ud_up_edge;
  wire ud_dn_edge;
  wire sg_edge;
  wire [15:0] tmr_t_word;
  wire [15:0] tmr_h_word;
  wire [15:0] acc_t_lo;
  wire [15:0] acc_t_hi;
  wire [15:0] acc_h_lo;
  wire [15:0] acc_h_hi;
  wire [15:0] cnt_up_word;
  wire [15:0] cnt_ud_lo;
  wire [15:0] cnt_ud_hi;
  wire [15:0] cnt_sg_word;

  // tick dividers; one-cycle tick each time the count wraps
  // free-running bases: a timer's first count lands 1 to N cycles after its input turns on
  always @*
  begin
    next_tenth_tick = (tenth_div == TENTH_CYC - 1);
    next_hund_tick = (hund_div == HUNDREDTH_CYC - 1);
    if (next_tenth_tick)
    begin
      next_tenth_div = 32'h0;
    end
    else
    begin
      next_tenth_div = tenth_div + 32'h1;
    end
    if (next_hund_tick)
    begin
      next_hund_div = 32'h0;
    end
    else
    begin
      next_hund_div = hund_div + 32'h1;
    end
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tenth_div <= 32'h0;
      hund_div <= 32'h0;
      tenth_tick <= 1'b0;
      hund_tick <= 1'b0;
    end
    else
    begin
      tenth_div <= next_tenth_div;
      hund_div <= next_hund_div;
      tenth_tick <= next_tenth_tick;
      hund_tick <= next_hund_tick;
    end
  end

  // held copies reset low, the idle level of the count inputs, so no false edge after reset
  assign up_edge = up_counter_count_i & ~up_q;
  assign ud_up_edge = up_down_counter_up_i & ~ud_up_q;
  assign ud_dn_edge = up_down_counter_down_i & ~ud_dn_q;
  assign sg_edge = stage_counter_count_i & ~sg_q;

  // input off clears at once, so a short drop between ticks is never missed
  always @*
  begin
    next_tmr_t = tmr_t;
    if (!tenth_second_timer_in_i)
    begin
      next_tmr_t = 14'h0;
    end
    else if (tenth_tick && (tmr_t != `PTCB_SHORT_MAX))
    begin
      next_tmr_t = tmr_t + 14'h1;
    end
  end

  // hundredth-second single-input timer
  always @*
  begin
    next_tmr_h = tmr_h;
    if (!hundredth_second_timer_in_i)
    begin
      next_tmr_h = 14'h0;
    end
    else if (hund_tick && (tmr_h != `PTCB_SHORT_MAX))
    begin
      next_tmr_h = tmr_h + 14'h1;
    end
  end

  // accumulating tenth timer; reset wins over enable
  always @*
  begin
    next_acc_t = acc_t;
    if (accumulating_tenth_timer_rst_i)
    begin
      next_acc_t = 27'h0;
    end
    else if (accumulating_tenth_timer_en_i && tenth_tick && (acc_t != `PTCB_LONG_MAX))
    begin
      next_acc_t = acc_t + 27'h1;
    end
  end

  // accumulating hundredth timer; reset wins over enable
  always @*
  begin
    next_acc_h = acc_h;
    if (accumulating_hundredth_timer_rst_i)
    begin
      next_acc_h = 27'h0;
    end
    else if (accumulating_hundredth_timer_en_i && hund_tick && (acc_h != `PTCB_LONG_MAX))
    begin
      next_acc_h = acc_h + 27'h1;
    end
  end

  // up counter; the maximum is held until reset
  always @*
  begin
    next_cnt_up = cnt_up;
    if (up_counter_rst_i)
    begin
      next_cnt_up = 14'h0;
    end
    else if (up_edge && (cnt_up != `PTCB_SHORT_MAX))
    begin
      next_cnt_up = cnt_up + 14'h1;
    end
  end

  // up/down counter; both inputs on means neither counts, the program keeps the idle one off
  always @*
  begin
    next_cnt_ud = cnt_ud;
    if (up_down_counter_rst_i)
    begin
      next_cnt_ud = 27'h0;
    end
    else if (ud_up_edge && !up_down_counter_down_i && (cnt_ud != `PTCB_LONG_MAX))
    begin
      next_cnt_ud = cnt_ud + 27'h1;
    end
    else if (ud_dn_edge && !up_down_counter_up_i && (cnt_ud != 27'h0))
    begin
      next_cnt_ud = cnt_ud - 27'h1;
    end
  end

  // stage counter; only the separate reset command or srst_i clears it
  always @*
  begin
    next_cnt_sg = cnt_sg;
    if (stage_counter_rst_cmd_i)
    begin
      next_cnt_sg = 14'h0;
    end
    else if (sg_edge && (cnt_sg != `PTCB_SHORT_MAX))
    begin
      next_cnt_sg = cnt_sg + 14'h1;
    end
  end

  // counters reset to zero and never wrap
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tmr_t <= 14'h0;
      tmr_h <= 14'h0;
      acc_t <= 27'h0;
      acc_h <= 27'h0;
      cnt_up <= 14'h0;
      cnt_ud <= 27'h0;
      cnt_sg <= 14'h0;
      up_q <= 1'b0;
      ud_up_q <= 1'b0;
      ud_dn_q <= 1'b0;
      sg_q <= 1'b0;
    end
    else
    begin
      tmr_t <= next_tmr_t;
      tmr_h <= next_tmr_h;
      acc_t <= next_acc_t;
      acc_h <= next_acc_h;
      cnt_up <= next_cnt_up;
      cnt_ud <= next_cnt_ud;
      cnt_sg <= next_cnt_sg;
      up_q <= up_counter_count_i;
      ud_up_q <= up_down_counter_up_i;
      ud_dn_q <= up_down_counter_down_i;
      sg_q <= stage_counter_count_i;
    end
  end

  // value words; long values take word n (low 16 bits) and n+1 (high bits)
  assign tmr_t_word = {2'b00, tmr_t};
  assign tmr_h_word = {2'b00, tmr_h};
  assign acc_t_lo = acc_t[15:0];
  assign acc_t_hi = {5'h0, acc_t[26:16]};
  assign acc_h_lo = acc_h[15:0];
  assign acc_h_hi = {5'h0, acc_h[26:16]};
  assign cnt_up_word = {2'b00, cnt_up};
  assign cnt_ud_lo = cnt_ud[15:0];
  assign cnt_ud_hi = {5'h0, cnt_ud[26:16]};
  assign cnt_sg_word = {2'b00, cnt_sg};

  // value memory decode
  always @*
  begin
    next_value = 16'h0;
    case (value_addr_i)
      11'd0: next_value = tmr_t_word;
      11'd1: next_value = tmr_h_word;
      11'd2: next_value = acc_t_lo;
      11'd3: next_value = acc_t_hi;
      11'd4: next_value = acc_h_lo;
      11'd5: next_value = acc_h_hi;
      `PTCB_CNT_BASE: next_value = cnt_up_word;
      `PTCB_CNT_BASE + 11'd1: next_value = cnt_ud_lo;
      `PTCB_CNT_BASE + 11'd2: next_value = cnt_ud_hi;
      `PTCB_CNT_BASE + 11'd3: next_value = cnt_sg_word;
      default: next_value = 16'h0;
    endcase
  end

  // presets are live ports, so a preset changed while running takes effect at once
  always @*
  begin
    next_timer_status = 6'h0;
    next_counter_bits = 4'h0;
    next_timer_status[0] = (tmr_t >= tenth_second_timer_preset_i);
    next_timer_status[1] = (tmr_h >= hundredth_second_timer_preset_i);
    next_timer_status[2] = (acc_t >= accumulating_tenth_timer_preset_i);
    // words 3 and 5 hold upper value halves, so their bits stay off
    next_timer_status[4] = (acc_h >= accumulating_hundredth_timer_preset_i);
    next_counter_bits[0] = (cnt_up >= up_counter_preset_i);
    next_counter_bits[1] = (cnt_ud >= up_down_counter_preset_i);
    next_counter_bits[3] = (cnt_sg >= stage_counter_preset_i);
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      value_data_o <= 16'h0;
      timer_status_o <= 6'h0;
      counter_bit_space_o <= 4'h0;
    end
    else
    begin
      value_data_o <= next_value;
      timer_status_o <= next_timer_status;
      counter_bit_space_o <= next_counter_bits;
    end
  end

endmodule // ptcb_timer_counter_bank

// [ptcb_chk_assertions.sv]
// concurrent checks on the timer and counter bank ports
`timescale 1ns/1ps
module ptcb_chk (
  input wire clk_i,
  input wire srst_i,
  input wire tenth_second_timer_in_i,
  input wire [13:0] tenth_second_timer_preset_i,
  input wire hundredth_second_timer_in_i,
  input wire [13:0] hundredth_second_timer_preset_i,
  input wire accumulating_tenth_timer_rst_i,
  input wire [26:0] accumulating_tenth_timer_preset_i,
  input wire accumulating_hundredth_timer_rst_i,
  input wire [26:0] accumulating_hundredth_timer_preset_i,
  input wire up_counter_rst_i,
  input wire [13:0] up_counter_preset_i,
  input wire up_down_counter_rst_i,
  input wire [26:0] up_down_counter_preset_i,
  input wire [15:0] value_data_o,
  input wire [5:0] timer_status_o,
  input wire [3:0] counter_bit_space_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_reset_zero: assert property (disable iff (1'b0) srst_i |=>
    value_data_o == 16'h0 && timer_status_o == 6'h0 && counter_bit_space_o == 4'h0)
    else $error("outputs not cleared by reset");
  chk_tenth_off: assert property ((!tenth_second_timer_in_i &&
    tenth_second_timer_preset_i != 14'h0) [*3] |-> !timer_status_o[0])
    else $error("tenth timer status on with input off");
  chk_hundredth_off: assert property ((!hundredth_second_timer_in_i &&
    hundredth_second_timer_preset_i != 14'h0) [*3] |-> !timer_status_o[1])
    else $error("hundredth timer status on with input off");
  chk_acc_tenth_rst: assert property ((accumulating_tenth_timer_rst_i &&
    accumulating_tenth_timer_preset_i != 27'h0) [*3] |-> !timer_status_o[2])
    else $error("accumulating tenth status on in reset");
  chk_acc_hund_rst: assert property ((accumulating_hundredth_timer_rst_i &&
    accumulating_hundredth_timer_preset_i != 27'h0) [*3] |-> !timer_status_o[4])
    else $error("accumulating hundredth status on in reset");
  chk_up_rst: assert property ((up_counter_rst_i &&
    up_counter_preset_i != 14'h0) [*3] |-> !counter_bit_space_o[0])
    else $error("up counter status on in reset");
  chk_updown_rst: assert property ((up_down_counter_rst_i &&
    up_down_counter_preset_i != 27'h0) [*3] |-> !counter_bit_space_o[1])
    else $error("up/down counter status on in reset");
  chk_upper_bits: assert property (timer_status_o[3] == 1'b0 &&
    timer_status_o[5] == 1'b0 && counter_bit_space_o[2] == 1'b0)
    else $error("status set for an upper value word");
endmodule // ptcb_chk
bind ptcb_timer_counter_bank ptcb_chk i_ptcb_chk (.*);

// [ptcb_prog_model.sv]
// program logic model that pulses the counter count inputs
`timescale 1ns/1ps
module ptcb_prog_model (
  input wire clk_i,
  output logic [3:0] cnt_o
);
  // bit 0 up, 1 up-down up, 2 up-down down, 3 stage; only one is ever high
  initial cnt_o = 4'h0;
  task pulse(input integer k, input integer n);
    repeat (n)
    begin
      cnt_o[k] = 1'b1;
      @(posedge clk_i);
      #1;
      cnt_o[k] = 1'b0;
      @(posedge clk_i);
      #1;
    end
  endtask
endmodule // ptcb_prog_model

// [plc_timer_counter_bank_tb.sv]
// self-checking bench for the timer and counter bank
`timescale 1ns/1ps
module plc_timer_counter_bank_tb;
  logic clk_i = 0, srst_i = 1, tenth_second_timer_in_i = 0, hundredth_second_timer_in_i = 0;
  logic accumulating_tenth_timer_en_i = 0, accumulating_tenth_timer_rst_i = 1;
  logic accumulating_hundredth_timer_en_i = 0, accumulating_hundredth_timer_rst_i = 1;
  logic up_counter_rst_i = 0, up_down_counter_rst_i = 0, stage_counter_rst_cmd_i = 0;
  logic [13:0] tenth_second_timer_preset_i = 14'h3, hundredth_second_timer_preset_i = 14'h270f;
  logic [13:0] up_counter_preset_i = 14'h3, stage_counter_preset_i = 14'h2;
  logic [26:0] accumulating_tenth_timer_preset_i = 27'h3, up_down_counter_preset_i = 27'h3;
  logic [26:0] accumulating_hundredth_timer_preset_i = 27'h3;
  logic [10:0] value_addr_i = 11'h0;
  logic [15:0] v;
  wire [3:0] cnt;
  wire [15:0] value_data_o;
  wire [5:0] timer_status_o;
  wire [3:0] counter_bit_space_o;
  wire up_counter_count_i = cnt[0];
  wire up_down_counter_up_i = cnt[1];
  wire up_down_counter_down_i = cnt[2];
  wire stage_counter_count_i = cnt[3];
  integer err_total = 0, num_checks = 0, cyc = 0;
  ptcb_timer_counter_bank #(.TENTH_CYC(10), .HUNDREDTH_CYC(4)) i_ptcb_timer_counter_bank (.*);
  ptcb_prog_model i_ptcb_prog_model (.clk_i(clk_i), .cnt_o(cnt));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 70000)
    begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  task end_of_test;
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks = num_checks + 1;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total = err_total + 1;
    end
  endtask
  task rd(input logic [10:0] a, input string n, input logic [15:0] e);
    value_addr_i = a;
    tick(2);
    chk(n, e, value_data_o);
  endtask
  task t_single;
    tenth_second_timer_in_i = 1;
    tick(45);
    value_addr_i = 11'h0;
    tick(2);
    chk("t0 range", 16'h1, {15'h0, value_data_o >= 3 && value_data_o <= 5});
    chk("t0 status", 16'h1, {15'h0, timer_status_o[0]});
    tenth_second_timer_in_i = 0;
    tick(3);
    rd(11'h0, "t0 clear", 16'h0);
    chk("t0 status", 16'h0, {15'h0, timer_status_o[0]});
  endtask
  task t_fast_max;
    hundredth_second_timer_in_i = 1;
    tick(40100);
    rd(11'h1, "t1 max", 16'h270f);
    chk("t1 status", 16'h1, {15'h0, timer_status_o[1]});
    hundredth_second_timer_in_i = 0;
  endtask
  task t_acc;
    accumulating_tenth_timer_rst_i = 0;
    accumulating_hundredth_timer_rst_i = 0;
    accumulating_tenth_timer_en_i = 1;
    accumulating_hundredth_timer_en_i = 1;
    tick(45);
    accumulating_tenth_timer_en_i = 0;
    value_addr_i = 11'h2;
    tick(2);
    v = value_data_o;
    chk("acc run", 16'h1, {15'h0, v >= 16'h3 && v <= 16'h5});
    value_addr_i = 11'h4;
    tick(2);
    chk("acc fast", 16'h1, {15'h0, value_data_o >= 16'hb});
    chk("acc fast faster", 16'h1, {15'h0, value_data_o > v});
    chk("acc fast status", 16'h1, {15'h0, timer_status_o[4]});
    tick(30);
    rd(11'h2, "acc hold", v);
    rd(11'h3, "acc upper", 16'h0);
    chk("acc status", 16'h1, {15'h0, timer_status_o[2]});
    accumulating_tenth_timer_en_i = 1;
    tick(25);
    value_addr_i = 11'h2;
    tick(2);
    chk("acc resume", 16'h1, {15'h0, value_data_o >= v + 2});
    accumulating_tenth_timer_rst_i = 1;
    accumulating_hundredth_timer_rst_i = 1;
    tick(25);
    rd(11'h2, "acc reset", 16'h0);
    rd(11'h4, "acc fast reset", 16'h0);
  endtask
  task t_count;
    i_ptcb_prog_model.pulse(0, 3);
    rd(11'h3e8, "up count", 16'h3);
    chk("up status", 16'h1, {15'h0, counter_bit_space_o[0]});
    i_ptcb_prog_model.pulse(1, 5);
    i_ptcb_prog_model.pulse(2, 2);
    rd(11'h3e9, "updown count", 16'h3);
    chk("updown status", 16'h1, {15'h0, counter_bit_space_o[1]});
    i_ptcb_prog_model.pulse(3, 2);
    rd(11'h3eb, "stage count", 16'h2);
    chk("stage status", 16'h1, {15'h0, counter_bit_space_o[3]});
    up_counter_rst_i = 1;
    up_down_counter_rst_i = 1;
    stage_counter_rst_cmd_i = 1;
    tick(3);
    rd(11'h3e8, "up reset", 16'h0);
    rd(11'h3e9, "updown reset", 16'h0);
    rd(11'h3eb, "stage reset", 16'h0);
    up_counter_rst_i = 0;
    stage_counter_rst_cmd_i = 0;
    i_ptcb_prog_model.pulse(0, 10000);
    rd(11'h3e8, "up max", 16'h270f);
  endtask
  initial
  begin
    tick(8);
    srst_i = 0;
    tick(1);
    t_single;
    t_fast_max;
    t_acc;
    t_count;
    end_of_test;
  end
endmodule // plc_timer_counter_bank_tb
